// file: logic/lks_pkg.sv
`default_nettype none
package lks_pkg;
  localparam int NUM_SEG     = 24;
  localparam int NUM_COM     = 8;
  localparam int SCAN_PINS   = 8;
  localparam int SCAN_BASE   = 16;
  localparam int SCAN_LEN    = 6;
  localparam int KEY_BLANK   = 2;
  localparam int KEY_END     = 1;
  localparam int KR_PINS     = 8;
  localparam int LCD_DIV_DEF = 6104;
  localparam int ADDR_W      = 12;
  localparam int INT_W       = 2;

  localparam logic [ADDR_W-1:0] ADDR_CTRL      = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_KEY_MODE  = 12'h004;
  localparam logic [ADDR_W-1:0] ADDR_SCAN_A    = 12'h008;
  localparam logic [ADDR_W-1:0] ADDR_SCAN_B    = 12'h00c;
  localparam logic [ADDR_W-1:0] ADDR_STATUS    = 12'h010;
  localparam logic [ADDR_W-1:0] ADDR_INT_STAT  = 12'h014;
  localparam logic [ADDR_W-1:0] ADDR_INT_MASK  = 12'h018;
  localparam logic [3:0]        DMEM_PAGE      = 4'h1;

  localparam int CTRL_KSE_BIT  = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int INT_KEY_BIT   = 0;
  localparam int INT_SCAN_BIT  = 1;

  localparam logic [2:0]       CTRL_RST     = 3'h0;
  localparam logic [7:0]       KEY_MODE_RST = 8'h00;
  localparam logic [7:0]       SCAN_RST     = 8'hff;
  localparam logic [INT_W-1:0] INT_RST      = 2'h0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    MUX_STATIC = 2'b00,
    MUX_FOUR   = 2'b01,
    MUX_EIGHT  = 2'b10
  } lks_mux_t;

  typedef struct packed {
    logic [NUM_COM-1:0] comSel;
    logic               acPhase;
    logic [NUM_SEG-1:0] segPhase;
    logic               scanActive;
  } lks_pins_t;
endpackage : lks_pkg
`default_nettype wire

// file: logic/lks_sync.sv
`timescale 1ns/10ps
`default_nettype none
module lks_sync #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);
  logic [W-1:0] stage1_ff;
  logic [W-1:0] stage2_ff;

  // Key returns idle high through their pull-ups
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      stage1_ff <= '1;
      stage2_ff <= '1;
    end
    else
    begin
      stage1_ff <= asyncIn;
      stage2_ff <= stage1_ff;
    end
  end

  assign syncOut = stage2_ff;
endmodule : lks_sync
`default_nettype wire

// file: logic/lks_frame_timer.sv
`timescale 1ns/10ps
`default_nettype none
module lks_frame_timer
#(
  parameter int LCD_DIV  = lks_pkg::LCD_DIV_DEF,
  parameter int SCAN_CNT = lks_pkg::SCAN_LEN
) (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [3:0] numSlots,
  input  wire logic       scanEn,
  output logic      [2:0] slotIdx,
  output logic            inScan,
  output logic      [2:0] scanIdx,
  output logic            acPhase
);
  import lks_pkg::*;
  localparam int DIV_W = $clog2(LCD_DIV);
  localparam logic [DIV_W-1:0] DIV_LAST  = DIV_W'(LCD_DIV - 1);
  localparam logic [2:0]       SCAN_LAST = 3'(SCAN_CNT - 1);

  logic [DIV_W-1:0] div_ff;
  logic [DIV_W-1:0] nxt_div;
  logic [2:0]       slot_ff;
  logic [2:0]       nxt_slot;
  logic             inScan_ff;
  logic             nxt_inScan;
  logic [2:0]       scanIdx_ff;
  logic [2:0]       nxt_scanIdx;
  logic             ac_ff;
  logic             nxt_ac;
  logic             tick;

  always_comb
  begin
    tick        = (div_ff == DIV_LAST);
    nxt_div     = tick ? '0 : div_ff + 1'b1;
    nxt_slot    = slot_ff;
    nxt_inScan  = inScan_ff;
    nxt_scanIdx = scanIdx_ff;
    nxt_ac      = ac_ff;
    if (tick)
    begin
      if (inScan_ff)
      begin
        if (scanIdx_ff == SCAN_LAST)
        begin
          nxt_inScan = 1'b0;
          nxt_slot   = 3'h0;
          nxt_ac     = ~ac_ff;
        end
        else
          nxt_scanIdx = scanIdx_ff + 3'h1;
      end
      else if (slot_ff >= 3'(numSlots - 4'h1))
      begin
        // Scan period closes each frame so the shared pins alternate roles
        if (scanEn)
        begin
          nxt_inScan  = 1'b1;
          nxt_scanIdx = 3'h0;
        end
        else
        begin
          nxt_slot = 3'h0;
          nxt_ac   = ~ac_ff;
        end
      end
      else
        nxt_slot = slot_ff + 3'h1;
    end
    // A switch to fewer slots must not keep a higher common active until the next tick
    if (!tick && !inScan_ff && {1'b0, slot_ff} >= numSlots)
    begin
      nxt_div  = '0;
      nxt_slot = 3'h0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      div_ff     <= '0;
      slot_ff    <= 3'h0;
      inScan_ff  <= 1'b0;
      scanIdx_ff <= 3'h0;
      ac_ff      <= 1'b0;
    end
    else
    begin
      div_ff     <= nxt_div;
      slot_ff    <= nxt_slot;
      inScan_ff  <= nxt_inScan;
      scanIdx_ff <= nxt_scanIdx;
      ac_ff      <= nxt_ac;
    end
  end

  assign slotIdx = slot_ff;
  assign inScan  = inScan_ff;
  assign scanIdx = scanIdx_ff;
  assign acPhase = ac_ff;
endmodule : lks_frame_timer
`default_nettype wire

// file: logic/lks_lcd_keyscan.sv
// Summary of operation
// - Each display memory byte drives one segment; bit n selects during common n.
// - Four-slot mode uses only the low four bits, one per common 0 to 3.
// - Eight-slot mode uses all eight bits, bit n for common n.
// - A selected segment is driven in opposite phase to its active common.
// - Key returns are ignored for two LCD clocks after the scan flag rises.
// - Key returns are ignored during the last LCD clock of the scan period.
// - An enabled key return pulled low sets the key interrupt flag.
// - Low return while a scan pin is low marks that key pressed.
// - In the scan period shared pins output scan port register bits.
// - Low nibble sets the first half of the scan period, high nibble the second.
// - With scanning on, shared pins alternate display and scan output every frame.
// - Only the eight key returns scan; mode bit n includes return pin n.
// - Commons show no display drive during the scan output period.
// - Key scan output is unavailable in static display mode.
//
// Added by the designer: the address map and the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module lks_lcd_keyscan
#(
  parameter int LCD_DIV = lks_pkg::LCD_DIV_DEF
) (
  input  wire logic                       clk,
  input  wire logic                       sys_rst,
  input  wire logic [lks_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic      [1:0]                 s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [lks_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic      [31:0]                s_axi_rdata,
  output logic      [1:0]                 s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  input  wire logic [lks_pkg::KR_PINS-1:0] keyReturnInput,
  output lks_pkg::lks_pins_t              lcdPins,
  output logic                            scanPeriodFlag,
  output logic                            irq
);
  import lks_pkg::*;
  localparam logic [2:0] BLANK_IDX = 3'(KEY_BLANK);
  localparam logic [2:0] END_IDX   = 3'(SCAN_LEN - 1 - KEY_END);
  localparam logic [2:0] HALF_IDX  = 3'(SCAN_LEN / 2);

  logic [ADDR_W-1:0]  awAddr_ff, nxt_awAddr;
  logic               awHeld_ff, nxt_awHeld;
  logic [7:0]         wByte_ff, nxt_wByte;
  logic               wLane_ff, nxt_wLane;
  logic               wHeld_ff, nxt_wHeld;
  logic               bValid_ff, nxt_bValid;
  logic [1:0]         bResp_ff, nxt_bResp;
  logic               rValid_ff, nxt_rValid;
  logic [31:0]        rData_ff, nxt_rData;
  logic [1:0]         rResp_ff, nxt_rResp;
  logic [2:0]         ctrl_ff, nxt_ctrl;
  logic [7:0]         keyMode_ff, nxt_keyMode;
  logic [7:0]         scanA_ff, nxt_scanA;
  logic [7:0]         scanB_ff, nxt_scanB;
  logic [INT_W-1:0]   intStat_ff, nxt_intStat;
  logic [INT_W-1:0]   intMask_ff, nxt_intMask;
  logic [7:0]         dmem_ff [NUM_SEG];
  logic [7:0]         nxt_dmem [NUM_SEG];
  lks_pins_t          pins_ff, nxt_pins;
  logic               scanDly_ff;
  logic               doWrite;
  logic               wrOk;
  logic [INT_W-1:0]   evt;
  logic [INT_W-1:0]   w1c;
  logic               keyEvt;
  logic               keyWin;
  logic               scanEnEff;
  logic               staticMode;
  lks_mux_t           mode;
  logic [3:0]         numSlots;
  logic [2:0]         slotIdx;
  logic               inScan;
  logic [2:0]         scanIdx;
  logic               acPhase;
  logic [KR_PINS-1:0] krSync;
  logic [7:0]         scanBits;
  logic               segOn;

  lks_sync #(.W(KR_PINS)) u_kr_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .asyncIn (keyReturnInput),
    .syncOut (krSync)
  );

  lks_frame_timer #(.LCD_DIV(LCD_DIV), .SCAN_CNT(SCAN_LEN)) u_timer (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .numSlots (numSlots),
    .scanEn   (scanEnEff),
    .slotIdx  (slotIdx),
    .inScan   (inScan),
    .scanIdx  (scanIdx),
    .acPhase  (acPhase)
  );

  assign mode       = lks_mux_t'(ctrl_ff[CTRL_MODE_LSB +: 2]);
  assign staticMode = (mode == MUX_STATIC);
  assign scanEnEff  = ctrl_ff[CTRL_KSE_BIT] && !staticMode;

  always_comb
  begin
    unique case (mode)
      MUX_STATIC: numSlots = 4'h1;
      MUX_FOUR:   numSlots = 4'h4;
      MUX_EIGHT:  numSlots = 4'h8;
      default:    numSlots = 4'h8;
    endcase
  end

  // Blanking covers pull-up settling; the final clock is input end handling
  assign keyWin = inScan && (scanIdx >= BLANK_IDX) && (scanIdx <= END_IDX);
  assign keyEvt = keyWin && |(~krSync & keyMode_ff);
  assign evt    = {inScan && !scanDly_ff, keyEvt};
  assign doWrite = awHeld_ff && wHeld_ff;
  assign wrOk    = doWrite && wLane_ff;
  assign w1c     = (wrOk && awAddr_ff == ADDR_INT_STAT) ? wByte_ff[INT_W-1:0] : '0;

  always_comb
  begin
    nxt_awAddr  = awAddr_ff;
    nxt_awHeld  = awHeld_ff;
    nxt_wByte   = wByte_ff;
    nxt_wLane   = wLane_ff;
    nxt_wHeld   = wHeld_ff;
    nxt_bValid  = bValid_ff && !s_axi_bready;
    nxt_bResp   = bResp_ff;
    nxt_ctrl    = ctrl_ff;
    nxt_keyMode = keyMode_ff;
    nxt_scanA   = scanA_ff;
    nxt_scanB   = scanB_ff;
    nxt_intMask = intMask_ff;
    nxt_dmem    = dmem_ff;
    // A key event landing on a clearing write still survives
    nxt_intStat = (intStat_ff & ~w1c) | evt;
    if (s_axi_awvalid && s_axi_awready)
    begin
      nxt_awAddr = s_axi_awaddr;
      nxt_awHeld = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      nxt_wByte = s_axi_wdata[7:0];
      nxt_wLane = s_axi_wstrb[0];
      nxt_wHeld = 1'b1;
    end
    if (doWrite)
    begin
      nxt_awHeld = 1'b0;
      nxt_wHeld  = 1'b0;
      nxt_bValid = 1'b1;
      nxt_bResp  = RESP_OKAY;
      if (awAddr_ff[11:8] == DMEM_PAGE && awAddr_ff[7:2] < 6'(NUM_SEG))
      begin
        if (wLane_ff)
          nxt_dmem[awAddr_ff[6:2]] = wByte_ff;
      end
      else
      begin
        unique case (awAddr_ff)
          ADDR_CTRL:     if (wLane_ff) nxt_ctrl = wByte_ff[2:0];
          ADDR_KEY_MODE: if (wLane_ff) nxt_keyMode = wByte_ff;
          ADDR_SCAN_A:   if (wLane_ff) nxt_scanA = wByte_ff;
          ADDR_SCAN_B:   if (wLane_ff) nxt_scanB = wByte_ff;
          ADDR_INT_MASK: if (wLane_ff) nxt_intMask = wByte_ff[INT_W-1:0];
          ADDR_INT_STAT: nxt_bResp = RESP_OKAY;
          ADDR_STATUS:   nxt_bResp = RESP_OKAY;
          default:       nxt_bResp = RESP_SLVERR;
        endcase
      end
    end
  end

  always_comb
  begin
    nxt_rValid = rValid_ff && !s_axi_rready;
    nxt_rData  = rData_ff;
    nxt_rResp  = rResp_ff;
    if (s_axi_arvalid && s_axi_arready)
    begin
      nxt_rValid = 1'b1;
      nxt_rResp  = RESP_OKAY;
      nxt_rData  = 32'h0;
      if (s_axi_araddr[11:8] == DMEM_PAGE && s_axi_araddr[7:2] < 6'(NUM_SEG))
        nxt_rData[7:0] = dmem_ff[s_axi_araddr[6:2]];
      else
      begin
        unique case (s_axi_araddr)
          ADDR_CTRL:     nxt_rData[2:0] = ctrl_ff;
          ADDR_KEY_MODE: nxt_rData[7:0] = keyMode_ff;
          ADDR_SCAN_A:   nxt_rData[7:0] = scanA_ff;
          ADDR_SCAN_B:   nxt_rData[7:0] = scanB_ff;
          ADDR_STATUS:   nxt_rData[15:0] = {krSync, scanIdx, slotIdx, acPhase, inScan};
          ADDR_INT_STAT: nxt_rData[INT_W-1:0] = intStat_ff;
          ADDR_INT_MASK: nxt_rData[INT_W-1:0] = intMask_ff;
          default:       nxt_rResp = RESP_SLVERR;
        endcase
      end
    end
  end

  // Display drive; scan period hands shared pins to the port latches
  always_comb
  begin
    nxt_pins            = '0;
    nxt_pins.acPhase    = acPhase;
    nxt_pins.scanActive = inScan;
    scanBits            = 8'h0;
    segOn               = 1'b0;
    for (int s = 0; s < NUM_SEG; s++)
    begin
      segOn = staticMode ? dmem_ff[s][0] : dmem_ff[s][slotIdx];
      nxt_pins.segPhase[s] = segOn ? ~acPhase : acPhase;
    end
    if (staticMode)
      nxt_pins.comSel = '1;
    else
      nxt_pins.comSel = NUM_COM'(1) << slotIdx;
    if (inScan)
    begin
      nxt_pins.comSel = '0;
      if (scanIdx < HALF_IDX)
        scanBits = {scanB_ff[3:0], scanA_ff[3:0]};
      else
        scanBits = {scanB_ff[7:4], scanA_ff[7:4]};
      for (int s = 0; s < NUM_SEG; s++)
        nxt_pins.segPhase[s] = acPhase;
      for (int p = 0; p < SCAN_PINS; p++)
        nxt_pins.segPhase[SCAN_BASE + p] = scanBits[p];
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      awAddr_ff  <= '0;
      awHeld_ff  <= 1'b0;
      wByte_ff   <= 8'h0;
      wLane_ff   <= 1'b0;
      wHeld_ff   <= 1'b0;
      bValid_ff  <= 1'b0;
      bResp_ff   <= RESP_OKAY;
      rValid_ff  <= 1'b0;
      rData_ff   <= 32'h0;
      rResp_ff   <= RESP_OKAY;
      ctrl_ff    <= CTRL_RST;
      keyMode_ff <= KEY_MODE_RST;
      scanA_ff   <= SCAN_RST;
      scanB_ff   <= SCAN_RST;
      intStat_ff <= INT_RST;
      intMask_ff <= INT_RST;
      pins_ff    <= '0;
      scanDly_ff <= 1'b0;
      for (int s = 0; s < NUM_SEG; s++)
        dmem_ff[s] <= 8'h0;
    end
    else
    begin
      awAddr_ff  <= nxt_awAddr;
      awHeld_ff  <= nxt_awHeld;
      wByte_ff   <= nxt_wByte;
      wLane_ff   <= nxt_wLane;
      wHeld_ff   <= nxt_wHeld;
      bValid_ff  <= nxt_bValid;
      bResp_ff   <= nxt_bResp;
      rValid_ff  <= nxt_rValid;
      rData_ff   <= nxt_rData;
      rResp_ff   <= nxt_rResp;
      ctrl_ff    <= nxt_ctrl;
      keyMode_ff <= nxt_keyMode;
      scanA_ff   <= nxt_scanA;
      scanB_ff   <= nxt_scanB;
      intStat_ff <= nxt_intStat;
      intMask_ff <= nxt_intMask;
      pins_ff    <= nxt_pins;
      scanDly_ff <= inScan;
      dmem_ff    <= nxt_dmem;
    end
  end

  assign s_axi_awready  = !awHeld_ff && !bValid_ff;
  assign s_axi_wready   = !wHeld_ff && !bValid_ff;
  assign s_axi_bvalid   = bValid_ff;
  assign s_axi_bresp    = bResp_ff;
  assign s_axi_arready  = !rValid_ff;
  assign s_axi_rvalid   = rValid_ff;
  assign s_axi_rdata    = rData_ff;
  assign s_axi_rresp    = rResp_ff;
  assign lcdPins        = pins_ff;
  assign scanPeriodFlag = inScan;
  assign irq            = |(intStat_ff & intMask_ff);

  default clocking dcb @(posedge clk); endclocking
  default disable iff (sys_rst);

  AST_KEY_BLANK: assert property (keyEvt |-> inScan && scanIdx >= 3'h2)
    else $error("key accepted inside the blanking time");
  AST_KEY_END: assert property (keyEvt |-> scanIdx != 3'(SCAN_LEN - 1))
    else $error("key accepted in the last scan clock");
  AST_KEY_SET: assert property (keyEvt |=> intStat_ff[INT_KEY_BIT])
    else $error("key flag not set after key event");
  AST_KEY_MODE: assert property (keyMode_ff == 8'h00
    |=> !$rose(intStat_ff[INT_KEY_BIT]))
    else $error("key flag set with every key return excluded");
  AST_COM_OFF: assert property (lcdPins.scanActive |-> lcdPins.comSel == '0)
    else $error("common driven in scan period");
  AST_SEG_OPP: assert property (!inScan && !staticMode && dmem_ff[0][slotIdx]
    |=> lcdPins.segPhase[0] != lcdPins.acPhase)
    else $error("selected segment not in opposite phase");
  AST_FOUR_SLOT: assert property (mode == MUX_FOUR && $stable(mode) && !inScan
    |-> slotIdx < 3'h4)
    else $error("four slot mode left slots 0 to 3");
  AST_SCAN_A0: assert property (inScan && scanIdx < HALF_IDX
    |=> lcdPins.segPhase[SCAN_BASE] == $past(scanA_ff[0]))
    else $error("scan pin 0 does not follow its latch bit");
  AST_STATIC_NOSCAN: assert property (!scanEnEff && !inScan |=> !inScan)
    else $error("scan period entered while disabled");
  AST_W_RESP: assert property (doWrite |=> s_axi_bvalid)
    else $error("write answered late");

  COV_KEY: cover property (keyEvt ##1 irq);
  COV_SCAN_RISE: cover property ($rose(inScan));
  COV_CLEAR: cover property (intStat_ff[INT_KEY_BIT] ##1 !intStat_ff[INT_KEY_BIT]);
endmodule : lks_lcd_keyscan
`default_nettype wire

// file: tb/lks_key_matrix.sv
`timescale 1ns/10ps
`default_nettype none
module lks_key_matrix (
  input  wire logic [63:0]        keyPress,
  input  wire logic [7:0]         groundRet,
  input  wire lks_pkg::lks_pins_t pins,
  output logic      [7:0]         keyRet
);
  import lks_pkg::*;

  // Diodes let a closed key only pull its return down; pull-ups hold every other return high unless groundRet pulls it low
  always_comb
  begin
    keyRet = ~groundRet;
    for (int s = 0; s < SCAN_PINS; s++)
      for (int r = 0; r < KR_PINS; r++)
        if (keyPress[s*KR_PINS+r] && !pins.segPhase[SCAN_BASE+s])
          keyRet[r] = 1'b0;
  end
endmodule : lks_key_matrix
`default_nettype wire

// file: tb/lks_lcd_keyscan_tb.sv
`timescale 1ns/10ps
`default_nettype none
module lks_lcd_keyscan_tb;
  import lks_pkg::*;
  localparam int DIV = 4;
  logic              clk;
  logic              sys_rst;
  logic [ADDR_W-1:0] awAddr;
  logic [ADDR_W-1:0] arAddr;
  logic              awValid, wValid, bReady, arValid, rReady;
  logic              awReady, wReady, bValid, arReady, rValid, irq, scanFlag;
  logic [31:0]       wData, rData, rd;
  logic [3:0]        wStrb;
  logic [1:0]        bResp, rResp, rsp;
  logic [7:0]        keyRet, groundRet, scanA, scanB;
  logic [63:0]       keyPress;
  lks_pins_t         pins;
  lks_mux_t          mode;
  logic [7:0]        dmem [NUM_SEG];
  logic              monEn, prevScan, prevIrq, seen;
  int                failCount, cmpCount, scanCnt, dispCnt, flagCnt;

  lks_lcd_keyscan #(.LCD_DIV(DIV)) i_dut (
    .clk(clk), .sys_rst(sys_rst),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .keyReturnInput(keyRet), .lcdPins(pins), .scanPeriodFlag(scanFlag), .irq(irq)
  );

  lks_key_matrix i_keys (.keyPress(keyPress), .groundRet(groundRet), .pins(pins), .keyRet(keyRet));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic compare(input logic [31:0] got, input logic [31:0] exp);
    cmpCount++;
    if (got !== exp)
    begin
      failCount++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : compare

  task automatic checkReg(input logic [31:0] got, input logic [31:0] exp);
    compare(got, exp);
  endtask : checkReg

  task automatic checkPin(input logic [31:0] got, input logic [31:0] exp);
    compare(got, exp);
  endtask : checkPin

  task automatic endOfTest();
    $display("Comparisons %0d, mismatches %0d", cmpCount, failCount);
    if (failCount == 0 && cmpCount > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : endOfTest

  // Ready is sampled on the falling edge so the following rising edge is the handshake
  task automatic axiWrite(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] s);
    logic aT, wT, bT;
    @(posedge clk);
    awAddr  <= a;
    wData   <= d;
    wStrb   <= s;
    awValid <= 1'b1;
    wValid  <= 1'b1;
    do
    begin
      @(negedge clk);
      aT = awValid && awReady;
      wT = wValid && wReady;
      @(posedge clk);
      if (aT) awValid <= 1'b0;
      if (wT) wValid <= 1'b0;
    end
    while (awValid || wValid);
    bReady <= 1'b1;
    do
    begin
      @(negedge clk);
      bT  = bValid;
      rsp = bResp;
      @(posedge clk);
    end
    while (!bT);
    bReady <= 1'b0;
  endtask : axiWrite

  task automatic axiRead(input logic [ADDR_W-1:0] a);
    logic t;
    @(posedge clk);
    arAddr  <= a;
    arValid <= 1'b1;
    do
    begin
      @(negedge clk);
      t = arReady;
      @(posedge clk);
    end
    while (!t);
    arValid <= 1'b0;
    rReady  <= 1'b1;
    do
    begin
      @(negedge clk);
      t   = rValid;
      rd  = rData;
      rsp = rResp;
      @(posedge clk);
    end
    while (!t);
    rReady <= 1'b0;
  endtask : axiRead

  task automatic runMode(input lks_mux_t md, input logic en);
    axiWrite(ADDR_CTRL, {29'h0, md, en}, 4'hf);
    mode = md;
    repeat (150) @(posedge clk);
    monEn = 1'b1;
    repeat (300) @(posedge clk);
    monEn = 1'b0;
  endtask : runMode

  task automatic keyCase(input int st, input int len, input logic [7:0] km, input logic [7:0] a,
                         input logic [7:0] b, input logic [63:0] kp, input logic ex);
    axiWrite(ADDR_KEY_MODE, {24'h0, km}, 4'hf);
    do axiRead(ADDR_STATUS); while (!rd[0]);
    axiWrite(ADDR_SCAN_A, {24'h0, a}, 4'hf);
    axiWrite(ADDR_SCAN_B, {24'h0, b}, 4'hf);
    scanA = a;
    scanB = b;
    keyPress <= kp;
    @(negedge scanFlag);
    axiWrite(ADDR_INT_STAT, 32'h3, 4'hf);
    @(posedge scanFlag);
    repeat (st*DIV) @(posedge clk);
    groundRet <= (len > 0) ? 8'hff : 8'h00;
    repeat (len*DIV) @(posedge clk);
    groundRet <= 8'h00;
    @(negedge scanFlag);
    repeat (4) @(posedge clk);
    axiRead(ADDR_INT_STAT);
    checkReg({31'h0, rd[0]}, {31'h0, ex});
    checkReg({31'h0, rd[INT_SCAN_BIT]}, 32'h1);
    checkPin({31'h0, irq}, {31'h0, ex});
    keyPress <= '0;
  endtask : keyCase

  // Pin model: display slots from the memory image, scan slots from the two scan registers
  always @(negedge clk)
  begin : mon
    int idx, slots, cnt, want;
    logic [31:0] exp;
    slots = (mode == MUX_STATIC) ? 1 : (mode == MUX_FOUR) ? 4 : 8;
    flagCnt = scanFlag ? flagCnt + 1 : 0;
    if (!sys_rst && irq && !prevIrq)
      checkPin({31'h0, scanFlag && flagCnt > 2*DIV && flagCnt <= 5*DIV+1}, 32'h1);
    if (pins.scanActive != prevScan)
    begin
      cnt  = pins.scanActive ? dispCnt : scanCnt;
      want = pins.scanActive ? slots*DIV : SCAN_LEN*DIV;
      if (seen && monEn) checkPin(32'(cnt), 32'(want));
      seen = monEn;
      scanCnt = 0;
      dispCnt = 0;
    end
    idx = 0;
    if (pins.scanActive)
    begin
      for (int k = 0; k < 4; k++)
      begin
        exp[16+k] = (scanCnt / DIV < 3) ? scanA[k] : scanA[k+4];
        exp[20+k] = (scanCnt / DIV < 3) ? scanB[k] : scanB[k+4];
      end
      exp[15:0]  = {16{pins.acPhase}};
      exp[31:24] = 8'h00;
    end
    else
    begin
      for (int c = NUM_COM-1; c >= 0; c--)
        if (pins.comSel[c]) idx = c;
      exp[31:24] = (mode == MUX_STATIC) ? 8'hff : (idx < slots) ? 8'h01 << idx : 8'h00;
      for (int n = 0; n < NUM_SEG; n++)
        exp[n] = dmem[n][idx] ^ pins.acPhase;
    end
    if (monEn) checkPin({pins.comSel, pins.segPhase}, exp);
    if (monEn && mode == MUX_STATIC) checkPin({31'h0, scanFlag}, 32'h0);
    if (pins.scanActive) scanCnt++;
    else dispCnt++;
    prevScan = pins.scanActive;
    prevIrq  = irq;
  end

  initial
  begin
    #1600000;
    failCount++;
    endOfTest();
  end

  initial
  begin : main
    logic [ADDR_W-1:0] ra [8];
    logic [31:0] rv [8];
    logic [31:0] v;
    ra = '{ADDR_CTRL, ADDR_KEY_MODE, ADDR_SCAN_A, ADDR_SCAN_B, ADDR_INT_STAT, ADDR_INT_MASK,
           12'h100, 12'h060};
    rv = '{32'h0, 32'h0, 32'hff, 32'hff, 32'h0, 32'h0, 32'h0, 32'h0};
    {sys_rst, awAddr, arAddr, wData, wStrb} = {1'b1, 60'h0};
    {awValid, wValid, bReady, arValid, rReady, monEn, prevScan, prevIrq, seen} = 9'h0;
    {groundRet, keyPress, scanA, scanB} = {72'h0, 16'hffff};
    {failCount, cmpCount, scanCnt, dispCnt, flagCnt} = '0;
    mode = MUX_STATIC;
    foreach (dmem[i]) dmem[i] = 8'h00;
    void'($urandom(26380));
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    foreach (ra[i])
    begin
      axiRead(ra[i]);
      checkReg(rd, rv[i]);
      checkReg({30'h0, rsp}, {30'h0, (i == 7) ? RESP_SLVERR : RESP_OKAY});
    end
    for (int i = 0; i < NUM_SEG + 2; i++)
    begin
      v = $urandom;
      if (i == 4) v[7:0] = 8'h31;
      if (i == 12) v[7:0] = 8'h0d;
      axiWrite((i < NUM_SEG) ? 12'h100 + 12'(4*i) : ADDR_SCAN_A + 12'(4*(i-NUM_SEG)), v, 4'hf);
      axiRead((i < NUM_SEG) ? 12'h100 + 12'(4*i) : ADDR_SCAN_A + 12'(4*(i-NUM_SEG)));
      checkReg(rd, {24'h0, v[7:0]});
      if (i < NUM_SEG) dmem[i] = v[7:0];
      else if (i == NUM_SEG) scanA = v[7:0];
      else scanB = v[7:0];
    end
    axiWrite(12'h110, 32'h5a, 4'h0);
    axiRead(12'h110);
    checkReg(rd, 32'h31);
    axiWrite(12'h060, 32'h5a, 4'hf);
    checkReg({30'h0, rsp}, {30'h0, RESP_SLVERR});
    runMode(MUX_STATIC, 1'b0);
    runMode(MUX_STATIC, 1'b1);
    runMode(MUX_FOUR, 1'b1);
    runMode(MUX_EIGHT, 1'b1);
    runMode(MUX_FOUR, 1'b0);
    runMode(lks_mux_t'(2'b11), 1'b1);
    axiWrite(ADDR_CTRL, {29'h0, MUX_FOUR, 1'b1}, 4'hf);
    mode = MUX_FOUR;
    axiWrite(ADDR_INT_MASK, 32'h1, 4'hf);
    keyCase(0, 1, 8'h01, 8'hff, 8'hff, 64'h0, 1'b0);
    keyCase(5, 1, 8'h01, 8'hff, 8'hff, 64'h0, 1'b0);
    keyCase(3, 1, 8'h00, 8'hff, 8'hff, 64'h0, 1'b0);
    keyCase(3, 1, 8'h01, 8'hff, 8'hff, 64'h0, 1'b1);
    axiWrite(ADDR_INT_MASK, 32'h0, 4'hf);
    checkPin({31'h0, irq}, 32'h0);
    axiWrite(ADDR_INT_STAT, 32'h1, 4'hf);
    axiRead(ADDR_INT_STAT);
    checkReg({31'h0, rd[0]}, 32'h0);
    axiWrite(ADDR_INT_MASK, 32'h1, 4'hf);
    keyCase(0, 0, 8'h01, 8'hfd, 8'hff, 64'h100, 1'b1);
    keyCase(0, 0, 8'h01, 8'hff, 8'hff, 64'h100, 1'b0);
    keyCase(0, 0, 8'h01, 8'hdf, 8'hff, 64'h100, 1'b1);
    keyCase(0, 0, 8'h04, 8'hff, 8'hfe, 64'h4_0000_0000, 1'b1);
    endOfTest();
  end
endmodule : lks_lcd_keyscan_tb
`default_nettype wire
